// >>> status_mux_params.svh
// Offsets, field positions, reset values and response codes for the status pin B mux.
`ifndef STATUS_MUX_PARAMS_SVH
`define STATUS_MUX_PARAMS_SVH

// =====================================================================
// Register map (byte addresses on the AXI4-Lite slave)
// =====================================================================
`define ADDR_STATUS_B_CTRL   8'h1c
`define ADDR_EVENT_STATUS    8'h40
`define ADDR_EVENT_MASK      8'h44
`define ADDR_INDICATOR_RAW   8'h48

// =====================================================================
// Control register fields and reset values
// =====================================================================
`define SEL_MSB              7
`define SEL_LSB              4
`define POL_BIT              3
`define SEL_RESET            4'h2
`define POL_RESET            1'b1
`define EVENT_COUNT          16
`define MASK_RESET           16'h0000
// Sources whose pin view is the divider output halved by a toggle stage.
`define HALVED_MASK          16'h18d8

// =====================================================================
// AXI response codes
// =====================================================================
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// >>> status_mux_pkg.sv
// Types for the status pin B mux; its input synchroniser uses none of them.
`timescale 1ns/100ps
package status_mux_pkg;

    // Source select codes for the status pin B.
    typedef enum logic [3:0] {
        SRC_PRI_MISSING  = 4'h0,
        SRC_SEC_MISSING  = 4'h1,
        SRC_PLL1_LOCK    = 4'h2,
        SRC_PLL1_RDIV    = 4'h3,
        SRC_PLL1_NDIV    = 4'h4,
        SRC_PLL2_LOCK    = 4'h5,
        SRC_PLL2_RDIV    = 4'h6,
        SRC_PLL2_NDIV    = 4'h7,
        SRC_PLL1_CAL     = 4'h8,
        SRC_PLL2_CAL     = 4'h9,
        SRC_ALERT        = 4'ha,
        SRC_PLL1_MDIV    = 4'hb,
        SRC_PLL2_MDIV    = 4'hc,
        SRC_NVM_BUSY     = 4'hd,
        SRC_PLL1_REVERT  = 4'he,
        SRC_PLL2_REVERT  = 4'hf
    } status_src_e;

    // Read channel states of the register slave.
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } rd_state_e;

endpackage

`include "status_mux_params.svh"

// =====================================================================
// Status pin B source mux
// =====================================================================
// Operation
// - Select field bits 7:4, resets to 0x2.
// - Codes 0x0, 0x1 show reference signal missing.
// - Codes 0x2, 0x5 show PLL lock missing.
// - Codes 0x3, 0x6 show halved R dividers.
// - Codes 0x4, 0x7 show halved N dividers.
// - Codes 0x8, 0x9 show VCO calibration active.
// - Codes 0xb, 0xc halved M; 0xd memory busy.
// - Codes 0xe, 0xf show automatic revert events.
// - Bit 3 polarity, one is active high.
// - Test override beats select and polarity.
// - Code 0xa shows combined flag alert.
module status_pin_b_source_mux
    import status_mux_pkg::*;
#(
    parameter int SRC_COUNT = `EVENT_COUNT,
    parameter int ADDR_W    = 8,
    parameter int DATA_W    = 32
) (
    // Clock, reset and clock enable.
    input  logic                 aclk,
    input  logic                 aresetn,
    input  logic                 clk_en,
    // AXI4-Lite write address and write data.
    input  logic [ADDR_W-1:0]    awaddr,
    input  logic                 awvalid,
    output logic                 awready,
    input  logic [DATA_W-1:0]    wdata,
    input  logic [DATA_W/8-1:0]  wstrb,
    input  logic                 wvalid,
    output logic                 wready,
    // AXI4-Lite write response.
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input  logic                 bready,
    // AXI4-Lite read address and read data.
    input  logic [ADDR_W-1:0]    araddr,
    input  logic                 arvalid,
    output logic                 arready,
    output logic [DATA_W-1:0]    rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input  logic                 rready,
    // Indicators from the clock generator, asynchronous to aclk.
    input  logic [SRC_COUNT-1:0] indicator_raw,
    // Test configuration from logic on aclk.
    input  logic                 test_override_en,
    input  logic                 test_override_value,
    // Pin and interrupt.
    output logic                 status_pin_b,
    output logic                 irq
);

    // =================================================================
    // Declarations
    // =================================================================
    localparam logic [SRC_COUNT-1:0] HALVED = SRC_COUNT'(`HALVED_MASK);

    logic [3:0]           sel_reg;
    logic [3:0]           sel_next;
    logic                 pol_reg;
    logic                 pol_next;
    logic [SRC_COUNT-1:0] mask_reg;
    logic [SRC_COUNT-1:0] mask_next;
    logic [SRC_COUNT-1:0] status_reg;
    logic [SRC_COUNT-1:0] status_next;
    logic [SRC_COUNT-1:0] prev_reg;
    logic [SRC_COUNT-1:0] toggle_reg;
    logic [SRC_COUNT-1:0] toggle_next;
    logic                 primed_reg;
    logic [SRC_COUNT-1:0] ind_sync;
    logic [SRC_COUNT-1:0] rise_raw;
    logic [SRC_COUNT-1:0] rise_vec;
    logic [SRC_COUNT-1:0] level_vec;
    logic                 selected;
    logic                 pin_next;
    logic                 pin_reg;
    logic                 irq_reg;
    logic                 awready_reg;
    logic                 awready_next;
    logic                 bvalid_reg;
    logic                 bvalid_next;
    logic [1:0]           bresp_reg;
    logic [1:0]           bresp_next;
    logic                 arready_reg;
    logic                 arready_next;
    logic [DATA_W-1:0]    rdata_reg;
    logic [DATA_W-1:0]    rdata_next;
    logic [1:0]           rresp_reg;
    logic [1:0]           rresp_next;
    logic                 rvalid_reg;
    rd_state_e            rd_state_reg;
    rd_state_e            rd_state_next;
    logic                 wr_fire;
    logic                 ar_take;
    logic                 aw_ctrl;
    logic                 aw_mask;
    logic                 aw_status;
    logic                 aw_raw;
    logic                 wr_known;
    logic                 ar_ctrl;
    logic                 ar_mask;
    logic                 ar_status;
    logic                 ar_raw;
    logic                 rd_known;
    logic [DATA_W-1:0]    rd_word;
    logic                 rd_clear;

    // =================================================================
    // Input synchroniser
    // =================================================================
    // Every indicator crosses into aclk through two flops before use.
    status_sync_2ff #(
        .WIDTH (SRC_COUNT)
    ) status_sync_2ff_i (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_en  (clk_en),
        .d       (indicator_raw),
        .q       (ind_sync)
    );

    // =================================================================
    // Write channel
    // =================================================================
    // Address and data are taken together, so one ready pulse covers both.
    assign wr_fire      = awvalid && awready_reg && wvalid;
    assign aw_ctrl      = (awaddr == ADDR_W'(`ADDR_STATUS_B_CTRL));
    assign aw_mask      = (awaddr == ADDR_W'(`ADDR_EVENT_MASK));
    assign aw_status    = (awaddr == ADDR_W'(`ADDR_EVENT_STATUS));
    assign aw_raw       = (awaddr == ADDR_W'(`ADDR_INDICATOR_RAW));
    assign wr_known     = aw_ctrl || aw_mask || aw_status || aw_raw;
    assign awready_next = !awready_reg && !bvalid_reg && awvalid && wvalid;
    assign bvalid_next  = wr_fire ? 1'b1 : ((bvalid_reg && bready) ? 1'b0 : bvalid_reg);
    assign bresp_next   = wr_fire ? (wr_known ? `RESP_OKAY : `RESP_SLVERR) : bresp_reg;

    // Control and mask fields; reserved bits 2:0 are never stored.
    assign sel_next  = (wr_fire && aw_ctrl && wstrb[0]) ?
                       wdata[`SEL_MSB:`SEL_LSB] : sel_reg;
    assign pol_next  = (wr_fire && aw_ctrl && wstrb[0]) ? wdata[`POL_BIT] : pol_reg;
    assign mask_next = (wr_fire && aw_mask && wstrb[0]) ? wdata[SRC_COUNT-1:0] : mask_reg;

    // =================================================================
    // Read channel
    // =================================================================
    assign ar_take      = arvalid && arready_reg;
    assign ar_ctrl      = (araddr == ADDR_W'(`ADDR_STATUS_B_CTRL));
    assign ar_mask      = (araddr == ADDR_W'(`ADDR_EVENT_MASK));
    assign ar_status    = (araddr == ADDR_W'(`ADDR_EVENT_STATUS));
    assign ar_raw       = (araddr == ADDR_W'(`ADDR_INDICATOR_RAW));
    assign rd_known     = ar_ctrl || ar_mask || ar_status || ar_raw;
    assign arready_next = !arready_reg && (rd_state_reg == RD_IDLE) && arvalid;
    assign rd_word      = ar_ctrl   ? DATA_W'({sel_reg, pol_reg, 3'b000}) :
                          ar_status ? DATA_W'(status_reg) :
                          ar_mask   ? DATA_W'(mask_reg) :
                          ar_raw    ? DATA_W'(ind_sync) : '0;
    assign rdata_next   = ar_take ? rd_word : rdata_reg;
    assign rresp_next   = ar_take ? (rd_known ? `RESP_OKAY : `RESP_SLVERR) : rresp_reg;

    // Read state: idle until an address is taken, then hold data until rready.
    always_comb begin
        rd_state_next = rd_state_reg;
        case (rd_state_reg)
            RD_IDLE: begin
                if (ar_take) begin
                    rd_state_next = RD_RESP;
                end
            end
            RD_RESP: begin
                if (rready) begin
                    rd_state_next = RD_IDLE;
                end
            end
            default: begin
                rd_state_next = RD_IDLE;
            end
        endcase
    end

    // =================================================================
    // Events and interrupt
    // =================================================================
    // The primed flag masks edges in the first cycle after reset only; an indicator high at reset still sets its event once through the sync flops.
    assign rise_raw    = ind_sync & ~prev_reg;
    assign rise_vec    = primed_reg ? rise_raw : '0;
    assign rd_clear    = ar_take && ar_status;
    // A new event in the cycle of the clearing read survives: set wins.
    assign status_next = (rd_clear ? '0 : status_reg) | rise_vec;
    assign toggle_next = toggle_reg ^ (rise_raw & HALVED);

    // =================================================================
    // Source mux
    // =================================================================
    // Divider sources show a halved copy; the rest pass their level straight.
    genvar gi;
    generate
        for (gi = 0; gi < SRC_COUNT; gi++) begin : g_level
            assign level_vec[gi] = HALVED[gi] ? toggle_reg[gi] : ind_sync[gi];
        end
    endgenerate

    assign selected = level_vec[sel_reg];
    // Test configuration overrides the select and polarity outright.
    assign pin_next = test_override_en ? test_override_value : (selected ~^ pol_reg);

    // =================================================================
    // Registers
    // =================================================================
    // Control register state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg <= `SEL_RESET;
            pol_reg <= `POL_RESET;
        end else if (clk_en) begin
            sel_reg <= sel_next;
            pol_reg <= pol_next;
        end
    end

    // Event, mask and toggle state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg   <= SRC_COUNT'(`MASK_RESET);
            status_reg <= '0;
            prev_reg   <= '0;
            toggle_reg <= '0;
            primed_reg <= 1'b0;
        end else if (clk_en) begin
            mask_reg   <= mask_next;
            status_reg <= status_next;
            prev_reg   <= ind_sync;
            toggle_reg <= toggle_next;
            primed_reg <= 1'b1;
        end
    end

    // Pin and interrupt flops, so both leave the block glitch free.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            pin_reg <= pin_next;
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    // Bus handshake flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg  <= 1'b0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= `RESP_OKAY;
            arready_reg  <= 1'b0;
            rdata_reg    <= '0;
            rresp_reg    <= `RESP_OKAY;
            rvalid_reg   <= 1'b0;
            rd_state_reg <= RD_IDLE;
        end else if (clk_en) begin
            awready_reg  <= awready_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            arready_reg  <= arready_next;
            rdata_reg    <= rdata_next;
            rresp_reg    <= rresp_next;
            rvalid_reg   <= (rd_state_next == RD_RESP);
            rd_state_reg <= rd_state_next;
        end
    end

    // Outputs straight from flops.
    assign awready      = awready_reg;
    assign wready       = awready_reg;
    assign bvalid       = bvalid_reg;
    assign bresp        = bresp_reg;
    assign arready      = arready_reg;
    assign rdata        = rdata_reg;
    assign rresp        = rresp_reg;
    assign rvalid       = rvalid_reg;
    assign status_pin_b = pin_reg;
    assign irq          = irq_reg;

    // =================================================================
    // Assertions
    // =================================================================
    chk_reset_select:
        assert property (@(posedge aclk) $rose(aresetn) |-> (sel_reg == `SEL_RESET) &&
                         (pol_reg == `POL_RESET))
        else $error("select or polarity not at reset value");
    chk_pin_polarity:
        assert property (@(posedge aclk) disable iff (!aresetn)
                         (clk_en && !test_override_en) |=>
                         (status_pin_b == $past(level_vec[sel_reg] ~^ pol_reg)))
        else $error("pin does not follow selected source");
    chk_override_wins:
        assert property (@(posedge aclk) disable iff (!aresetn)
                         (clk_en && test_override_en) |=>
                         (status_pin_b == $past(test_override_value)))
        else $error("test override not on pin");
    chk_reserved_zero:
        assert property (@(posedge aclk) disable iff (!aresetn)
                         (clk_en && ar_take && ar_ctrl) |=>
                         ((rdata[2:0] == 3'b000) && (rdata[7:4] == $past(sel_reg))))
        else $error("control read-back wrong");
    chk_halved_toggle:
        assert property (@(posedge aclk) disable iff (!aresetn)
                         (clk_en && rise_raw[3]) |=> (toggle_reg[3] != $past(toggle_reg[3])))
        else $error("halving stage did not toggle");
    chk_event_set_wins:
        assert property (@(posedge aclk) disable iff (!aresetn)
                         clk_en |=> ((status_reg & $past(rise_vec)) == $past(rise_vec)))
        else $error("event lost");
    chk_write_answer:
        assert property (@(posedge aclk) disable iff (!aresetn)
                         (clk_en && wr_fire) |=> bvalid)
        else $error("write response missing");
    chk_read_answer:
        assert property (@(posedge aclk) disable iff (!aresetn)
                         (clk_en && ar_take) |=> rvalid)
        else $error("read response missing");

endmodule

// =====================================================================
// Two-flop synchroniser
// =====================================================================
module status_sync_2ff #(
    parameter int WIDTH = 16
) (
    // Clock, reset and clock enable.
    input  logic             aclk,
    input  logic             aresetn,
    input  logic             clk_en,
    // Asynchronous input and its synchronised copy.
    input  logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // Only the second flop reads the first, so a metastable value has a cycle to settle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else if (clk_en) begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

// >>> tb.sv
// Testbench for the status pin B mux: register map, sources, polarity, override, events.
`timescale 1ns/100ps
`include "status_mux_params.svh"

// =====================================================================
// Board-side partner model
// =====================================================================
module board_model (
    // Clock.
    input  logic aclk,
    // Pin watched by the board.
    input  logic status_pin_b,
    // Registered copy seen by the board logic.
    output logic pin_seen
);
    // The board samples the pin on its own flop, so a level must stand a full cycle.
    always_ff @(posedge aclk) begin
        pin_seen <= status_pin_b;
    end
endmodule

// =====================================================================
// Bench top
// =====================================================================
module tb;
    logic        aclk                = 1'b0;
    logic        aresetn             = 1'b0;
    logic        clk_en              = 1'b1;
    logic [7:0]  awaddr              = 8'h00;
    logic        awvalid             = 1'b0;
    logic        awready;
    logic [31:0] wdata               = 32'h00000000;
    logic [3:0]  wstrb               = 4'h0;
    logic        wvalid              = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready              = 1'b1;
    logic [7:0]  araddr              = 8'h00;
    logic        arvalid             = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready              = 1'b1;
    logic [15:0] indicator_raw       = 16'h0000;
    logic        test_override_en    = 1'b0;
    logic        test_override_value = 1'b0;
    logic        status_pin_b;
    logic        irq;
    logic        pin_seen;
    logic [15:0] tog_exp             = 16'h0000;
    logic [31:0] rd_val;
    logic [1:0]  resp;
    logic [3:0]  level_codes [10]    = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h9, 4'ha, 4'hd,
                                         4'he, 4'hf};
    logic [3:0]  halved_codes [6]    = '{4'h3, 4'h4, 4'h6, 4'h7, 4'hb, 4'hc};
    int          fails               = 0;
    int          total_checks        = 0;

    // The 100 MHz clock.
    always #5 aclk = ~aclk;

    // Device under test.
    status_pin_b_source_mux status_pin_b_source_mux_i (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .clk_en              (clk_en),
        .awaddr              (awaddr),
        .awvalid             (awvalid),
        .awready             (awready),
        .wdata               (wdata),
        .wstrb               (wstrb),
        .wvalid              (wvalid),
        .wready              (wready),
        .bresp               (bresp),
        .bvalid              (bvalid),
        .bready              (bready),
        .araddr              (araddr),
        .arvalid             (arvalid),
        .arready             (arready),
        .rdata               (rdata),
        .rresp               (rresp),
        .rvalid              (rvalid),
        .rready              (rready),
        .indicator_raw       (indicator_raw),
        .test_override_en    (test_override_en),
        .test_override_value (test_override_value),
        .status_pin_b        (status_pin_b),
        .irq                 (irq)
    );

    // Board logic at the far side of the pin.
    board_model board_model_i (
        .aclk         (aclk),
        .status_pin_b (status_pin_b),
        .pin_seen     (pin_seen)
    );

    // Compares a register word.
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compares a pin or interrupt level.
    task automatic cmp_pin(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compares a bus response code.
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write: address and data offered together, each released when taken.
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
                             output logic [1:0] rsp);
        logic aw_open;
        logic w_open;
        aw_open = 1'b1;
        w_open  = 1'b1;
        awaddr  <= addr;
        awvalid <= 1'b1;
        wdata   <= data;
        wstrb   <= 4'hf;
        wvalid  <= 1'b1;
        while (aw_open || w_open) begin
            @(posedge aclk);
            if (aw_open && awready) begin
                awvalid <= 1'b0;
                aw_open = 1'b0;
            end
            if (w_open && wready) begin
                wvalid <= 1'b0;
                w_open = 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        rsp = bresp;
    endtask

    // Read: address held until taken, data taken at the edge rvalid is seen.
    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
                            output logic [1:0] rsp);
        araddr  <= addr;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        data = rdata;
        rsp  = rresp;
    endtask

    // Writes the control register.
    task automatic set_ctrl(input logic [3:0] code, input logic pol);
        logic [1:0] rsp;
        axi_write(`ADDR_STATUS_B_CTRL, {24'h000000, code, pol, 3'b000}, rsp);
        cmp_resp(rsp, `RESP_OKAY);
    endtask

    // Covers two sync flops, the pin flop and the board flop with margin.
    task automatic settle();
        repeat (6) @(posedge aclk);
    endtask
    task automatic close_out();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Test sequence.
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`ADDR_STATUS_B_CTRL, rd_val, resp);
        cmp_reg(rd_val, {24'h000000, `SEL_RESET, `POL_RESET, 3'b000});
        cmp_resp(resp, `RESP_OKAY);
        $display("test reset_value done");
        axi_write(`ADDR_STATUS_B_CTRL, 32'h000000ff, resp);
        axi_read(`ADDR_STATUS_B_CTRL, rd_val, resp);
        cmp_reg(rd_val, 32'h000000f8);
        $display("test reserved_bits done");
        for (int k = 0; k < 10; k++) begin
            set_ctrl(level_codes[k], 1'b1);
            indicator_raw[level_codes[k]] <= 1'b1;
            settle();
            cmp_pin(pin_seen, 1'b1);
            set_ctrl(level_codes[k], 1'b0);
            settle();
            cmp_pin(pin_seen, 1'b0);
            indicator_raw[level_codes[k]] <= 1'b0;
            settle();
            cmp_pin(pin_seen, 1'b1);
        end
        $display("test level_sources done");
        for (int k = 0; k < 6; k++) begin
            set_ctrl(halved_codes[k], 1'b1);
            for (int p = 0; p < 2; p++) begin
                indicator_raw[halved_codes[k]] <= 1'b1;
                settle();
                tog_exp[halved_codes[k]] = ~tog_exp[halved_codes[k]];
                cmp_pin(pin_seen, tog_exp[halved_codes[k]]);
                indicator_raw[halved_codes[k]] <= 1'b0;
                settle();
                cmp_pin(pin_seen, tog_exp[halved_codes[k]]);
            end
        end
        $display("test halved_sources done");
        set_ctrl(4'h0, 1'b1);
        test_override_en    <= 1'b1;
        test_override_value <= 1'b1;
        settle();
        cmp_pin(pin_seen, 1'b1);
        test_override_value <= 1'b0;
        indicator_raw[0]    <= 1'b1;
        settle();
        cmp_pin(pin_seen, 1'b0);
        test_override_en <= 1'b0;
        settle();
        cmp_pin(pin_seen, 1'b1);
        indicator_raw[0] <= 1'b0;
        settle();
        $display("test override done");
        axi_write(`ADDR_EVENT_MASK, 32'h00000001, resp);
        cmp_resp(resp, `RESP_OKAY);
        axi_read(`ADDR_EVENT_STATUS, rd_val, resp);
        cmp_reg(rd_val, 32'h0000ffff);
        settle();
        cmp_pin(irq, 1'b0);
        axi_read(`ADDR_EVENT_STATUS, rd_val, resp);
        cmp_reg(rd_val, 32'h00000000);
        indicator_raw[0] <= 1'b1;
        settle();
        cmp_pin(irq, 1'b1);
        axi_read(`ADDR_EVENT_STATUS, rd_val, resp);
        cmp_reg(rd_val, 32'h00000001);
        settle();
        cmp_pin(irq, 1'b0);
        $display("test events done");
        axi_write(8'h80, 32'h00000000, resp);
        cmp_resp(resp, `RESP_SLVERR);
        axi_read(8'h80, rd_val, resp);
        cmp_resp(resp, `RESP_SLVERR);
        $display("test unmapped done");
        clk_en           <= 1'b0;
        indicator_raw[0] <= 1'b0;
        settle();
        cmp_pin(pin_seen, 1'b1);
        clk_en <= 1'b1;
        settle();
        cmp_pin(pin_seen, 1'b0);
        $display("test clock_enable done");
        close_out();
    end

    // Watchdog: the tests take about five hundred cycles, this allows ten thousand.
    initial begin
        #100000;
        fails++;
        close_out();
    end
endmodule
